// ### inc/soca_pkg.sv
package soca_pkg;
   // Datapath geometry
   localparam int unsigned WIDTH = 12;
   localparam int unsigned GROUP_SIZE = 3;
   localparam int unsigned NUM_GROUPS = WIDTH / GROUP_SIZE;
   // Command encodings
   typedef enum logic [1:0] {
      SOCA_CMD_ADD,
      SOCA_CMD_SUB,
      SOCA_CMD_PASS
   } soca_cmd_t;
   // Reset value of the result register
   localparam logic [11:0] RESULT_RESET = 12'h000;
endpackage

// ### core/soca_group.sv
// One three-stage octal group: stage signals rolled up to group signals
module soca_group
(
   input wire logic [2:0] minuend,
   input wire logic [2:0] subtrahend,
   output logic [2:0] stage_borrow,
   output logic [2:0] stage_enable,
   output logic group_borrow,
   output logic group_enable
);
   // Per-stage borrow and enable
   always_comb
   begin
      stage_borrow = ~minuend & subtrahend;
      stage_enable = ~(minuend ^ subtrahend);
   end

   // Group borrow: a stage borrow with enables in every higher stage
   assign group_borrow = stage_borrow[2] | (stage_borrow[1] & stage_enable[2]) |
      (stage_borrow[0] & stage_enable[1] & stage_enable[2]);
   assign group_enable = &stage_enable;
endmodule // soca_group

// ### core/soca_adder.sv
module soca_adder
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic op_valid,
   input wire soca_pkg::soca_cmd_t op_cmd,
   input wire logic [11:0] operand_a,
   input wire logic [11:0] operand_b,
   output logic [11:0] result_q,
   output logic done_q,
   output logic [11:0] passed_borrow_q
);
   logic [11:0] min_w;
   logic [11:0] sub_w;
   logic [11:0] sb_w;
   logic [11:0] se_w;
   logic [3:0] gb_w;
   logic [3:0] ge_w;
   logic [3:0] gin_w;
   logic [11:0] bin_w;
   logic [11:0] toggle_w;
   logic [11:0] result_d;
   logic end_around_w;

   // Operand steering per command
   always_comb
   begin
      min_w = operand_b;
      sub_w = ~operand_a;
      case (op_cmd)
         soca_pkg::SOCA_CMD_ADD:
         begin
            min_w = operand_b;
            sub_w = ~operand_a;
         end
         soca_pkg::SOCA_CMD_SUB:
         begin
            min_w = operand_b;
            sub_w = operand_a;
         end
         soca_pkg::SOCA_CMD_PASS:
         begin
            min_w = operand_b;
            sub_w = 12'h000;
         end
         default:
         begin
            min_w = operand_b;
            sub_w = 12'h000;
         end
      endcase
   end

   // Four octal groups across twelve stages
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_grp
         soca_group u_grp
         (
            .minuend(min_w[3*g+2:3*g]),
            .subtrahend(sub_w[3*g+2:3*g]),
            .stage_borrow(sb_w[3*g+2:3*g]),
            .stage_enable(se_w[3*g+2:3*g]),
            .group_borrow(gb_w[g]),
            .group_enable(ge_w[g])
         );
      end
   endgenerate

   // End-around borrow: a borrow leaving the top group
   assign end_around_w = gb_w[3] | (gb_w[2] & ge_w[3]) | (gb_w[1] & ge_w[2] & ge_w[3]) |
      (gb_w[0] & ge_w[1] & ge_w[2] & ge_w[3]);

   // Group borrow inputs; end-around enters group 0
   always_comb
   begin
      gin_w[0] = end_around_w;
      gin_w[1] = gb_w[0] | (end_around_w & ge_w[0]);
      gin_w[2] = gb_w[1] | (gb_w[0] & ge_w[1]) | (end_around_w & ge_w[0] & ge_w[1]);
      gin_w[3] = gb_w[2] | (gb_w[1] & ge_w[2]) | (gb_w[0] & ge_w[1] & ge_w[2]) |
         (end_around_w & ge_w[0] & ge_w[1] & ge_w[2]);
   end

   // Stage borrow inputs distributed back down from group level
   always_comb
   begin
      for (int i = 0; i < 12; i++)
      begin
         if (i % 3 == 0)
            bin_w[i] = gin_w[i/3];
         else
            bin_w[i] = sb_w[i-1] | (se_w[i-1] & bin_w[i-1]);
      end
   end

   // Clear, toggle enable stages, then probe complements unborrowed
   always_comb
   begin
      toggle_w = 12'h000 | se_w;
      result_d = toggle_w ^ ~bin_w;
   end

   // Result register, one capture per request
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         result_q <= soca_pkg::RESULT_RESET;
      else if (op_valid)
         result_q <= result_d;
   end

   // Borrow acting on each stage, captured with the result
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         passed_borrow_q <= 12'h000;
      else if (op_valid)
         passed_borrow_q <= bin_w;
   end

   // Completion pulse
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         done_q <= 1'b0;
      else
         done_q <= op_valid;
   end

   // Checks
   sequence s_req;
      op_valid;
   endsequence

   property p_capture;
      @(posedge clock) disable iff (sys_rst) s_req |=> (result_q == $past(result_d)) && done_q;
   endproperty
   a_capture: assert property (p_capture) else $error("result not captured");

   property p_hold;
      @(posedge clock) disable iff (sys_rst) !op_valid |=> $stable(result_q) && !done_q;
   endproperty
   a_hold: assert property (p_hold) else $error("result changed without request");

   property p_add;
      @(posedge clock) disable iff (sys_rst)
         (op_valid && op_cmd == soca_pkg::SOCA_CMD_ADD && (operand_a & operand_b) != 12'hfff)
         |=> result_q == 12'(({1'b0, $past(operand_a)} + {1'b0, $past(operand_b)}) % 13'hfff);
   endproperty
   a_add: assert property (p_add) else $error("ones complement sum wrong");

   property p_sub;
      @(posedge clock) disable iff (sys_rst)
         (op_valid && op_cmd == soca_pkg::SOCA_CMD_SUB && !(operand_a == 12'h000 && operand_b == 12'hfff))
         |=> result_q == 12'(({1'b0, $past(operand_b)} + {1'b0, ~$past(operand_a)}) % 13'hfff);
   endproperty
   a_sub: assert property (p_sub) else $error("difference wrong");

   property p_sub_same;
      @(posedge clock) disable iff (sys_rst)
         (op_valid && op_cmd == soca_pkg::SOCA_CMD_SUB && operand_a == operand_b) |=> result_q == 12'h000;
   endproperty
   a_sub_same: assert property (p_sub_same) else $error("equal operands not zero");

   property p_pass;
      @(posedge clock) disable iff (sys_rst)
         (op_valid && op_cmd == soca_pkg::SOCA_CMD_PASS) |=> result_q == $past(operand_b);
   endproperty
   a_pass: assert property (p_pass) else $error("zero subtrahend changed operand");

   property p_borrow;
      @(posedge clock) disable iff (sys_rst)
         (op_valid && !min_w[0] && sub_w[0]) |=> passed_borrow_q[1];
   endproperty
   a_borrow: assert property (p_borrow) else $error("stage borrow not propagated");

   property p_enable;
      @(posedge clock) disable iff (sys_rst)
         (op_valid && min_w[0] == sub_w[0]) |=> passed_borrow_q[1] == passed_borrow_q[0];
   endproperty
   a_enable: assert property (p_enable) else $error("stage enable wrong");

   property p_grp_borrow;
      @(posedge clock) disable iff (sys_rst)
         (op_valid && !min_w[0] && sub_w[0] && min_w[2:1] == sub_w[2:1]) |=> passed_borrow_q[3];
   endproperty
   a_grp_borrow: assert property (p_grp_borrow) else $error("group borrow not passed");

   property p_grp_enable;
      @(posedge clock) disable iff (sys_rst)
         (op_valid && min_w[5:3] == sub_w[5:3]) |=> passed_borrow_q[6] == passed_borrow_q[3];
   endproperty
   a_grp_enable: assert property (p_grp_enable) else $error("group enable not passing");

   property p_absorb;
      @(posedge clock) disable iff (sys_rst)
         (op_valid && min_w[2] && !sub_w[2]) |=> !passed_borrow_q[3];
   endproperty
   a_absorb: assert property (p_absorb) else $error("borrow not absorbed");

   property p_wrap;
      @(posedge clock) disable iff (sys_rst)
         (op_valid && gb_w[3]) |=> passed_borrow_q[0];
   endproperty
   a_wrap: assert property (p_wrap) else $error("end-around borrow missing");

   property p_probe;
      @(posedge clock) disable iff (sys_rst)
         op_valid |=> result_q == ($past(se_w) ^ ~passed_borrow_q);
   endproperty
   a_probe: assert property (p_probe) else $error("probe result wrong");
endmodule // soca_adder

// ### tb/soca_proc_model.sv
module soca_proc_model
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic load,
   input wire soca_pkg::soca_cmd_t cmd_in,
   input wire logic [11:0] a_in,
   input wire logic [11:0] b_in,
   output logic op_valid,
   output soca_pkg::soca_cmd_t op_cmd,
   output logic [11:0] operand_a,
   output logic [11:0] operand_b
);
   timeunit 1ns;
   timeprecision 1ns;
   // One request per loaded cycle; operands scramble while idle
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         op_valid <= 1'b0;
         op_cmd <= soca_pkg::SOCA_CMD_PASS;
         operand_a <= 12'h000;
         operand_b <= 12'h000;
      end
      else
      begin
         op_valid <= load;
         op_cmd <= load ? cmd_in : soca_pkg::SOCA_CMD_SUB;
         operand_a <= load ? a_in : ~operand_a;
         operand_b <= load ? b_in : ~operand_b;
      end
   end
endmodule // soca_proc_model

// ### tb/tb_subtractive_ones_complement_adder.sv
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t %h %h", $time, g, e); end end
module tb_subtractive_ones_complement_adder;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0, sys_rst = 1'b1, load = 1'b0, op_valid, done_q;
   soca_pkg::soca_cmd_t cmd_in = soca_pkg::SOCA_CMD_ADD, op_cmd;
   logic [11:0] a_in = 12'h000, b_in = 12'h000, operand_a, operand_b, result_q, passed_borrow_q;
   int failures = 0, checked = 0;
   soca_proc_model proc (.clock(clock), .sys_rst(sys_rst), .load(load), .cmd_in(cmd_in), .a_in(a_in),
      .b_in(b_in), .op_valid(op_valid), .op_cmd(op_cmd), .operand_a(operand_a), .operand_b(operand_b));
   soca_adder dut (.clock(clock), .sys_rst(sys_rst), .op_valid(op_valid), .op_cmd(op_cmd), .operand_a(operand_a),
      .operand_b(operand_b), .result_q(result_q), .done_q(done_q), .passed_borrow_q(passed_borrow_q));
   // Clock
   initial
   begin
      forever #2.5 clock = ~clock;
   end
   // Borrow ripple with end-around wrap, returns {borrow, result}
   function automatic logic [23:0] expect_of(soca_pkg::soca_cmd_t c, logic [11:0] a, logic [11:0] b);
      logic [11:0] s, g, e, bin;
      int j;
      s = (c == soca_pkg::SOCA_CMD_SUB) ? a : (c == soca_pkg::SOCA_CMD_ADD) ? ~a : 12'h000;
      g = ~b & s;
      e = ~(b ^ s);
      bin = 12'h000;
      for (int i = 0; i < 12; i++)
      begin
         for (int k = 1; k <= 12; k++)
         begin
            j = (i + 12 - k) % 12;
            if (g[j]) bin[i] = 1'b1;
            if (g[j] || !e[j]) break;
         end
      end
      return {bin, (b ^ s) ^ bin};
   endfunction
   // Load one request, wait until it is captured, then judge it
   task automatic check_op(soca_pkg::soca_cmd_t c, logic [11:0] a, logic [11:0] b);
      logic [23:0] x;
      x = expect_of(c, a, b);
      load = 1'b1; cmd_in = c; a_in = a; b_in = b;
      @(posedge clock) #1 load = 1'b0;
      @(posedge clock) #1;
      `CHK(done_q, 1'b1)
      `CHK(result_q, x[11:0])
      `CHK(passed_borrow_q, x[23:12])
      @(posedge clock) #1;
      `CHK(done_q, 1'b0)
      `CHK(result_q, x[11:0])
   endtask
   task automatic t_walk();
      check_op(soca_pkg::SOCA_CMD_ADD, 12'h00a, 12'h00c);
      `CHK(result_q, 12'h016)
   endtask
   task automatic t_chain();
      check_op(soca_pkg::SOCA_CMD_SUB, 12'h001, 12'h000);
      `CHK(result_q, 12'hffe)
      check_op(soca_pkg::SOCA_CMD_SUB, 12'habc, 12'habc);
      `CHK(result_q, 12'h000)
   endtask
   task automatic t_cmds();
      logic [11:0] av[6] = '{12'h000, 12'hfff, 12'h555, 12'h008, 12'h7ff, 12'h1c7};
      logic [11:0] bv[6] = '{12'hfff, 12'h000, 12'haaa, 12'h000, 12'h800, 12'h238};
      for (int c = 0; c < 3; c++)
         for (int i = 0; i < 6; i++)
            check_op(soca_pkg::soca_cmd_t'(c), av[i], bv[i]);
   endtask
   task automatic t_b2b();
      load = 1'b1; cmd_in = soca_pkg::SOCA_CMD_ADD; a_in = 12'h123; b_in = 12'h456;
      @(posedge clock) #1 cmd_in = soca_pkg::SOCA_CMD_SUB; a_in = 12'h700;
      @(posedge clock) #1 load = 1'b0;
      `CHK(result_q, 12'h579)
      @(posedge clock) #1;
      `CHK({done_q, result_q}, 13'h1d55)
   endtask
   task automatic t_reset();
      check_op(soca_pkg::SOCA_CMD_ADD, 12'h111, 12'h222);
      sys_rst = 1'b1;
      #1;
      `CHK({done_q, result_q, passed_borrow_q}, 25'h0)
      @(posedge clock) #1 sys_rst = 1'b0;
      check_op(soca_pkg::SOCA_CMD_PASS, 12'h000, 12'h3a5);
   endtask
   task automatic complete_run();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #20000;
      failures++;
      complete_run();
   end
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clock);
      #1 sys_rst = 1'b0;
      t_walk();
      t_chain();
      t_cmds();
      t_b2b();
      t_reset();
      complete_run();
   end
endmodule // tb_subtractive_ones_complement_adder
